// ---- hw/stp_pkg.sv ----
// Operation
// R1 - Third port: four fixed inputs, four outputs
// R2 - Port lines carry handshakes, interrupts, timer, select
// R3 - Serial mode uses receive and transmit pins
// R4 - Bit rate comes from timer_a end-of-count
// R5 - Transmit adds start bit and two stops
// R6 - Eight bits sent; bit seven odd parity
// R7 - Each transmitted character raises irq_four
// R8 - Peer sends start, eight data, stop
// R9 - Receive parity error replaces bit seven
// R10 - Each received character raises irq_three
// R11 - Two 8-bit counters with 6-bit prescalers
// R12 - timer_b internal or external; timer_a internal
// R13 - Prescaler divides by one to sixty-four
// R14 - Counter decrements loaded count, one to 256
// R15 - Terminal count raises irq_four or irq_five
// R16 - Counters start, stop, resume, restart
// R17 - Single-pass or continuous reload modes
// R18 - Count readable without disturbance; prescaler not
// R19 - timer_b clock: internal/4 or timer input
// R20 - Timer input: clock, triggers, or gate
// R21 - Timer output: timer_a, timer_b, or clock
// R22 - timer_a end-of-count may clock timer_b
// R23 - Counters, external interrupts run during halt
// R24 - Received byte held; newer byte overwrites
package stp_pkg;
  localparam int          STP_DATA_W    = 8;
  localparam int          STP_CNT_W     = 8;
  localparam int          STP_PRE_W     = 6;
  localparam int          STP_PIN_N     = 4;
  localparam int          STP_IDX_RX    = 0;
  localparam int          STP_IDX_TIN   = 1;
  localparam int          STP_IDX_HSA   = 2;
  localparam int          STP_IDX_HSB   = 3;
  localparam logic [1:0]  STP_TDIV_LAST = 2'h3;
  localparam logic [3:0]  STP_OVS_LAST  = 4'hf;
  localparam logic [3:0]  STP_OVS_HALF  = 4'h7;
  localparam logic [3:0]  STP_TX_BITS   = 4'hb;
  localparam logic [3:0]  STP_RX_BITS   = 4'h8;
  localparam logic [1:0]  STP_TIN_CLK   = 2'h0;
  localparam logic [1:0]  STP_TIN_GATE  = 2'h1;
  localparam logic [1:0]  STP_TIN_TRIG  = 2'h2;
  localparam logic [1:0]  STP_TIN_RETRG = 2'h3;
  localparam logic [1:0]  STP_TOUT_A    = 2'h0;
  localparam logic [1:0]  STP_TOUT_B    = 2'h1;
  typedef enum logic [1:0] {
    STP_TX_IDLE = 2'b01,
    STP_TX_SEND = 2'b10
  } stp_tx_e;
  typedef enum logic [3:0] {
    STP_RX_IDLE  = 4'b0001,
    STP_RX_START = 4'b0010,
    STP_RX_DATA  = 4'b0100,
    STP_RX_STOP  = 4'b1000
  } stp_rx_e;
endpackage : stp_pkg

// ---- hw/stp_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module stp_counter #(
  parameter int CW = 8,
  parameter int PW = 6
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire logic          i_tick,
  input  wire logic          i_start,
  input  wire logic          i_stop,
  input  wire logic          i_resume,
  input  wire logic          i_cont,
  input  wire logic [CW-1:0] i_init,
  input  wire logic [PW-1:0] i_scale,
  output logic      [CW-1:0] o_count,
  output logic               o_run,
  output logic               o_eoc
);
  typedef struct packed {
    logic [PW-1:0] pre;
    logic [CW-1:0] cnt;
    logic          run;
    logic          eoc;
  } stp_cnt_s;

  stp_cnt_s cur_ff;
  stp_cnt_s nxt_cur;

  // Zero in the prescaler or counter stands for the full range
  always_comb begin
    nxt_cur     = cur_ff;
    nxt_cur.eoc = 1'b0;
    if (i_start) begin
      nxt_cur.pre = i_scale; // R16
      nxt_cur.cnt = i_init;
      nxt_cur.run = 1'b1;
    end else if (i_stop) begin
      nxt_cur.run = 1'b0; // R16
    end else if (i_resume) begin
      nxt_cur.run = 1'b1; // R16
    end else if (cur_ff.run && i_tick) begin
      if (cur_ff.pre == PW'(1)) begin
        nxt_cur.pre = i_scale; // R13
        if (cur_ff.cnt == CW'(1)) begin
          nxt_cur.eoc = 1'b1;
          nxt_cur.cnt = i_init; // R17
          nxt_cur.run = i_cont; // R17
        end else begin
          nxt_cur.cnt = cur_ff.cnt - CW'(1); // R14
        end
      end else begin
        nxt_cur.pre = cur_ff.pre - PW'(1); // R13
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Count is a plain flop view; prescaler is never exposed
  assign o_count = cur_ff.cnt; // R18
  assign o_run   = cur_ff.run;
  assign o_eoc   = cur_ff.eoc; // R11

  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  cnt_single_a : assert property ( // R17
    (cur_ff.run && i_tick && !i_start && !i_stop && !i_resume && !i_cont
     && cur_ff.pre == PW'(1) && cur_ff.cnt == CW'(1)) |=> (o_eoc && !o_run))
    else $error("single pass did not stop at terminal count");

  cnt_hold_a : assert property ( // R16
    (!cur_ff.run && !i_start && !i_resume) |=> $stable(cur_ff.cnt))
    else $error("stopped counter changed");
endmodule : stp_counter
`default_nettype wire

// ---- hw/stp_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module stp_unit #(
  parameter int DW = stp_pkg::STP_DATA_W,
  parameter int CW = stp_pkg::STP_CNT_W,
  parameter int PW = stp_pkg::STP_PRE_W
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire logic          i_serial_rx_pin,
  input  wire logic          i_timer_in_pin,
  input  wire logic          i_hs_in_pin_a,
  input  wire logic          i_hs_in_pin_b,
  output logic               o_serial_tx_pin,
  output logic               o_timer_out_pin,
  output logic               o_hs_out_pin_a,
  output logic               o_hs_out_pin_b,
  input  wire logic [3:0]    i_port_out,
  output logic      [3:0]    o_port_in,
  input  wire logic          i_uart_en,
  input  wire logic          i_parity_en,
  input  wire logic [DW-1:0] i_tx_data,
  input  wire logic          i_tx_load,
  output logic               o_tx_busy,
  output logic      [DW-1:0] o_rx_data,
  output logic               o_rx_full,
  input  wire logic          i_rx_read,
  input  wire logic          i_hs0_en,
  input  wire logic          i_hs0_out,
  input  wire logic          i_hs1_en,
  input  wire logic          i_hs1_out,
  input  wire logic          i_hs2_en,
  input  wire logic          i_hs2_out,
  input  wire logic          i_dm_en,
  input  wire logic          i_data_space_select_n,
  input  wire logic          i_tout_en,
  input  wire logic [1:0]    i_tout_sel,
  input  wire logic          i_ta_start,
  input  wire logic          i_ta_stop,
  input  wire logic          i_ta_resume,
  input  wire logic          i_ta_cont,
  input  wire logic [CW-1:0] i_ta_init,
  input  wire logic [PW-1:0] i_ta_scale,
  output logic      [CW-1:0] o_ta_count,
  input  wire logic          i_tb_start,
  input  wire logic          i_tb_stop,
  input  wire logic          i_tb_resume,
  input  wire logic          i_tb_cont,
  input  wire logic [CW-1:0] i_tb_init,
  input  wire logic [PW-1:0] i_tb_scale,
  output logic      [CW-1:0] o_tb_count,
  input  wire logic          i_tb_ext_en,
  input  wire logic [1:0]    i_tin_mode,
  input  wire logic          i_cascade,
  output logic               o_irq_zero,
  output logic               o_irq_one,
  output logic               o_irq_two,
  output logic               o_irq_three,
  output logic               o_irq_four,
  output logic               o_irq_five
);
  localparam int NP = stp_pkg::STP_PIN_N;

  typedef struct packed {
    logic [NP-1:0]   s1;
    logic [NP-1:0]   s2;
    logic [NP-1:0]   prev;
    logic [1:0]      div;
    stp_pkg::stp_tx_e tx_st;
    logic [10:0]     tx_sh;
    logic [3:0]      tx_bit;
    logic [3:0]      tx_ovs;
    logic            busy;
    stp_pkg::stp_rx_e rx_st;
    logic [DW-1:0]   rx_sh;
    logic [3:0]      rx_bit;
    logic [3:0]      rx_ovs;
    logic [DW-1:0]   rx_buf;
    logic            rx_full;
    logic            ta_tgl;
    logic            tb_tgl;
    logic            tx_pin;
    logic            tout_pin;
    logic            hs_a;
    logic            hs_b;
    logic [5:0]      irq;
  } stp_s;

  stp_s cur_ff;
  stp_s nxt_cur;

  logic [CW-1:0] ta_cnt;
  logic          ta_run;
  logic          ta_eoc;
  logic [CW-1:0] tb_cnt;
  logic          tb_run;
  logic          tb_eoc;
  logic          tclk;
  logic          tin_rise;
  logic          tb_tick;
  logic          tb_trig;
  logic          tx_acc;
  logic          tx_done;
  logic          rx_done;
  logic          rx_line;
  logic [DW-1:0] rx_byte;
  logic          rx_perr;
  logic [NP-1:0] fall;

  // Timer clock: processor clock divided by four, as an enable
  assign tclk     = (cur_ff.div == stp_pkg::STP_TDIV_LAST); // R19
  assign tin_rise = cur_ff.s2[stp_pkg::STP_IDX_TIN] & ~cur_ff.prev[stp_pkg::STP_IDX_TIN];
  assign fall     = cur_ff.prev & ~cur_ff.s2;
  assign rx_line  = cur_ff.s2[stp_pkg::STP_IDX_RX];

  // timer_b source: cascade, timer input clock, gate, or internal
  always_comb begin
    tb_tick = tclk; // R12
    tb_trig = 1'b0;
    if (i_cascade) begin
      tb_tick = ta_eoc; // R22
    end else if (i_tb_ext_en) begin
      unique case (i_tin_mode)
        stp_pkg::STP_TIN_CLK: tb_tick = tin_rise; // R20
        stp_pkg::STP_TIN_GATE: tb_tick = tclk & cur_ff.s2[stp_pkg::STP_IDX_TIN]; // R20
        stp_pkg::STP_TIN_TRIG: tb_trig = tin_rise & ~tb_run; // R20
        stp_pkg::STP_TIN_RETRG: tb_trig = tin_rise; // R20
      endcase
    end
  end

  // Neither counter sees a halt; timer_a runs on the free timer clock, timer_b on its selected tick source
  stp_counter #(
    .CW (CW),
    .PW (PW)
  ) u_timer_a (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_tick    (tclk), // R23
    .i_start   (i_ta_start),
    .i_stop    (i_ta_stop),
    .i_resume  (i_ta_resume),
    .i_cont    (i_ta_cont),
    .i_init    (i_ta_init),
    .i_scale   (i_ta_scale),
    .o_count   (ta_cnt),
    .o_run     (ta_run),
    .o_eoc     (ta_eoc)
  );

  stp_counter #(
    .CW (CW),
    .PW (PW)
  ) u_timer_b (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_tick    (tb_tick), // R23
    .i_start   (i_tb_start | tb_trig),
    .i_stop    (i_tb_stop),
    .i_resume  (i_tb_resume),
    .i_cont    (i_tb_cont),
    .i_init    (i_tb_init),
    .i_scale   (i_tb_scale),
    .o_count   (tb_cnt),
    .o_run     (tb_run),
    .o_eoc     (tb_eoc)
  );

  assign tx_acc  = i_uart_en && i_tx_load && (cur_ff.tx_st == stp_pkg::STP_TX_IDLE);
  assign rx_byte = {rx_line, cur_ff.rx_sh[DW-1:1]};
  assign rx_perr = ~^cur_ff.rx_sh; // R9

  always_comb begin
    nxt_cur      = cur_ff;
    tx_done      = 1'b0;
    rx_done      = 1'b0;
    nxt_cur.s1   = {i_hs_in_pin_b, i_hs_in_pin_a, i_timer_in_pin, i_serial_rx_pin}; // R1
    nxt_cur.s2   = cur_ff.s1;
    nxt_cur.prev = cur_ff.s2;
    nxt_cur.div  = cur_ff.div + 2'h1;
    if (ta_eoc) begin
      nxt_cur.ta_tgl = ~cur_ff.ta_tgl;
    end
    if (tb_eoc) begin
      nxt_cur.tb_tgl = ~cur_ff.tb_tgl;
    end

    // Transmitter: one bit per sixteen timer_a terminal counts
    unique case (cur_ff.tx_st)
      stp_pkg::STP_TX_IDLE: begin
        if (tx_acc) begin
          nxt_cur.tx_sh = {2'b11, i_parity_en ? ~^i_tx_data[6:0] : i_tx_data[7],
                           i_tx_data[6:0], 1'b0}; // R5 R6
          nxt_cur.tx_bit = '0;
          nxt_cur.tx_ovs = '0;
          nxt_cur.tx_st  = stp_pkg::STP_TX_SEND;
        end
      end
      stp_pkg::STP_TX_SEND: begin
        if (ta_eoc) begin
          nxt_cur.tx_ovs = cur_ff.tx_ovs + 4'h1; // R4
          if (cur_ff.tx_ovs == stp_pkg::STP_OVS_LAST) begin
            nxt_cur.tx_sh  = {1'b1, cur_ff.tx_sh[10:1]};
            nxt_cur.tx_bit = cur_ff.tx_bit + 4'h1;
            if (cur_ff.tx_bit == stp_pkg::STP_TX_BITS - 4'h1) begin
              tx_done       = 1'b1; // R7
              nxt_cur.tx_st = stp_pkg::STP_TX_IDLE;
            end
          end
        end
      end
      default: nxt_cur.tx_st = stp_pkg::STP_TX_IDLE;
    endcase

    // Receiver: oversampled on the same timer_a ticks
    unique case (cur_ff.rx_st)
      stp_pkg::STP_RX_IDLE: begin
        if (i_uart_en && ta_eoc && !rx_line) begin
          nxt_cur.rx_ovs = '0;
          nxt_cur.rx_st  = stp_pkg::STP_RX_START;
        end
      end
      stp_pkg::STP_RX_START: begin
        if (ta_eoc) begin
          nxt_cur.rx_ovs = cur_ff.rx_ovs + 4'h1;
          if (cur_ff.rx_ovs == stp_pkg::STP_OVS_HALF) begin
            // Glitch shorter than half a bit is dropped
            nxt_cur.rx_ovs = '0;
            nxt_cur.rx_bit = '0;
            nxt_cur.rx_st  = rx_line ? stp_pkg::STP_RX_IDLE : stp_pkg::STP_RX_DATA;
          end
        end
      end
      stp_pkg::STP_RX_DATA: begin
        if (ta_eoc) begin
          nxt_cur.rx_ovs = cur_ff.rx_ovs + 4'h1; // R4
          if (cur_ff.rx_ovs == stp_pkg::STP_OVS_LAST) begin
            nxt_cur.rx_sh  = rx_byte;
            nxt_cur.rx_bit = cur_ff.rx_bit + 4'h1;
            if (cur_ff.rx_bit == stp_pkg::STP_RX_BITS - 4'h1) begin
              nxt_cur.rx_st = stp_pkg::STP_RX_STOP;
            end
          end
        end
      end
      stp_pkg::STP_RX_STOP: begin
        // Only the first stop bit is awaited, so two-stop peers also fit
        if (ta_eoc && cur_ff.rx_ovs == stp_pkg::STP_OVS_LAST) begin
          rx_done        = 1'b1; // R8
          nxt_cur.rx_st  = stp_pkg::STP_RX_IDLE;
          nxt_cur.rx_buf = cur_ff.rx_sh; // R24
          if (i_parity_en) begin
            nxt_cur.rx_buf[DW-1] = rx_perr; // R9
          end
        end else if (ta_eoc) begin
          nxt_cur.rx_ovs = cur_ff.rx_ovs + 4'h1;
        end
      end
      default: nxt_cur.rx_st = stp_pkg::STP_RX_IDLE;
    endcase
    if (!i_uart_en) begin
      nxt_cur.rx_st = stp_pkg::STP_RX_IDLE;
    end

    // A new byte arriving with the read still counts as unread
    nxt_cur.rx_full = rx_done | (cur_ff.rx_full & ~i_rx_read); // R24
    nxt_cur.busy    = (nxt_cur.tx_st == stp_pkg::STP_TX_SEND);

    // Output pin routing
    if (i_uart_en) begin
      nxt_cur.tx_pin = (nxt_cur.tx_st == stp_pkg::STP_TX_SEND) ? nxt_cur.tx_sh[0] : 1'b1; // R3
    end else begin
      nxt_cur.tx_pin = i_port_out[3];
    end
    if (i_tout_en) begin
      unique case (i_tout_sel)
        stp_pkg::STP_TOUT_A: nxt_cur.tout_pin = nxt_cur.ta_tgl; // R21
        stp_pkg::STP_TOUT_B: nxt_cur.tout_pin = nxt_cur.tb_tgl; // R21
        default: nxt_cur.tout_pin = cur_ff.div[1]; // R21
      endcase
    end else if (i_hs2_en) begin
      nxt_cur.tout_pin = i_hs2_out; // R2
    end else begin
      nxt_cur.tout_pin = i_port_out[2];
    end
    nxt_cur.hs_a = i_hs0_en ? i_hs0_out : i_port_out[1]; // R2
    if (i_dm_en) begin
      nxt_cur.hs_b = i_data_space_select_n; // R2
    end else begin
      nxt_cur.hs_b = i_hs1_en ? i_hs1_out : i_port_out[0]; // R2
    end

    // Interrupt request pulses; pin requests on falling edges
    nxt_cur.irq[0] = fall[stp_pkg::STP_IDX_HSA]; // R2 R23
    nxt_cur.irq[1] = fall[stp_pkg::STP_IDX_HSB]; // R2
    nxt_cur.irq[2] = fall[stp_pkg::STP_IDX_TIN]; // R2
    nxt_cur.irq[3] = i_uart_en ? rx_done : fall[stp_pkg::STP_IDX_RX]; // R10
    nxt_cur.irq[4] = ta_eoc | tx_done; // R7 R15
    nxt_cur.irq[5] = tb_eoc; // R15
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cur_ff          <= '0;
      cur_ff.s1       <= '1;
      cur_ff.s2       <= '1;
      cur_ff.prev     <= '1;
      cur_ff.tx_st    <= stp_pkg::STP_TX_IDLE;
      cur_ff.rx_st    <= stp_pkg::STP_RX_IDLE;
      cur_ff.tx_pin   <= 1'b1;
      cur_ff.hs_b     <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign o_serial_tx_pin = cur_ff.tx_pin;
  assign o_timer_out_pin = cur_ff.tout_pin;
  assign o_hs_out_pin_a  = cur_ff.hs_a;
  assign o_hs_out_pin_b  = cur_ff.hs_b;
  assign o_port_in       = cur_ff.s2; // R1
  assign o_tx_busy       = cur_ff.busy;
  assign o_rx_data       = cur_ff.rx_buf;
  assign o_rx_full       = cur_ff.rx_full;
  assign o_ta_count      = ta_cnt; // R18
  assign o_tb_count      = tb_cnt; // R18
  assign o_irq_zero      = cur_ff.irq[0];
  assign o_irq_one       = cur_ff.irq[1];
  assign o_irq_two       = cur_ff.irq[2];
  assign o_irq_three     = cur_ff.irq[3];
  assign o_irq_four      = cur_ff.irq[4];
  assign o_irq_five      = cur_ff.irq[5];

  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence tx_take_s;
    tx_acc;
  endsequence

  sequence tx_start_bit_s;
    !o_serial_tx_pin && o_tx_busy;
  endsequence

  tx_start_a : assert property ( // R5
    tx_take_s |=> tx_start_bit_s)
    else $error("frame did not open with a start bit");

  tx_parity_a : assert property ( // R6
    (tx_acc && i_parity_en) |=> (cur_ff.tx_sh[8] == ~^$past(i_tx_data[6:0])))
    else $error("transmit parity bit wrong");

  tx_stop_a : assert property ( // R5
    tx_done |-> (cur_ff.tx_sh[0] && cur_ff.tx_sh[1]))
    else $error("stop bits not high at frame end");

  tx_irq_a : assert property ( // R7
    tx_done |=> o_irq_four)
    else $error("no irq_four after transmit");

  baud_src_a : assert property ( // R4
    (cur_ff.tx_st == stp_pkg::STP_TX_SEND && !ta_eoc) |=> $stable(cur_ff.tx_sh))
    else $error("transmit shifted without timer_a tick");

  rx_irq_a : assert property ( // R10
    (i_uart_en && rx_done) |=> (o_irq_three && o_rx_full))
    else $error("no irq_three after receive");

  rx_parity_a : assert property ( // R9
    (rx_done && i_parity_en) |=> (o_rx_data[DW-1] == ~^$past(cur_ff.rx_sh)))
    else $error("parity error flag wrong");

  rx_hold_a : assert property ( // R24
    (o_rx_full && !i_rx_read && !rx_done) |=> (o_rx_full && $stable(o_rx_data)))
    else $error("held byte lost before read");

  tmr_irq_a : assert property ( // R15
    (ta_eoc |=> o_irq_four) and (tb_eoc |=> o_irq_five))
    else $error("terminal count gave no request");

  dm_route_a : assert property ( // R2
    i_dm_en |=> (o_hs_out_pin_b == $past(i_data_space_select_n)))
    else $error("data select not routed");

  cascade_a : assert property ( // R22
    (i_cascade && tb_run && !ta_eoc && !i_tb_start && !i_tb_stop && !i_tb_resume)
    |=> $stable(tb_cnt))
    else $error("cascaded counter moved without timer_a");
endmodule : stp_unit
`default_nettype wire

// ---- testbench/stp_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module stp_peer #(
  parameter int BIT = 64
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_tx_line,
  output logic            o_rx_line,
  output logic      [7:0] o_got,
  output logic            o_stop_ok,
  output int              o_got_n
);
  initial begin
    o_rx_line = 1'h1;
    o_got = 8'h00;
    o_stop_ok = 1'h0;
    o_got_n = 0;
  end
  // Line idles high, so a released line reads as stop level
  task automatic send(input logic [7:0] b, input int nstop);
    @(posedge i_sys_clk);
    o_rx_line <= 1'h0;
    repeat (BIT) @(posedge i_sys_clk);
    for (int k = 0; k < 8; k++) begin
      o_rx_line <= b[k];
      repeat (BIT) @(posedge i_sys_clk);
    end
    o_rx_line <= 1'h1;
    repeat (BIT * nstop) @(posedge i_sys_clk);
  endtask : send
  // Mid-bit sampling leaves margin for tick jitter
  always begin
    @(negedge i_tx_line);
    repeat (BIT / 2) @(posedge i_sys_clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT) @(posedge i_sys_clk);
      o_got[k] = i_tx_line;
    end
    repeat (BIT) @(posedge i_sys_clk);
    o_stop_ok = i_tx_line;
    repeat (BIT) @(posedge i_sys_clk);
    o_stop_ok = o_stop_ok & i_tx_line;
    o_got_n++;
  end
endmodule : stp_peer
`default_nettype wire

// ---- testbench/test_serial_timer_port_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin comparisons++; if ((e) !== (s)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module test_serial_timer_port_unit;
  logic clk = 1'h0, rst = 1'h1, tin = 1'h0, hsa = 1'h1, hsb = 1'h1, uart = 1'h0, par = 1'h0;
  logic txl = 1'h0, rxr = 1'h0, h0e = 1'h0, h0o = 1'h0, h1e = 1'h0, h1o = 1'h0, h2e = 1'h0;
  logic h2o = 1'h0, dme = 1'h0, dsn = 1'h1, toe = 1'h0, tbx = 1'h0, casc = 1'h0;
  logic tas = 1'h0, tap = 1'h0, tar = 1'h0, tac = 1'h0, tbs = 1'h0, tbp = 1'h0, tbr = 1'h0;
  logic tbc = 1'h0, p;
  logic [1:0] tsel = 2'h0, tmode = 2'h0;
  logic [3:0] pout = 4'h8, pin;
  logic [5:0] tasc = 6'h01, tbsc = 6'h01;
  logic [7:0] txd = 8'h00, tai = 8'h01, tbi = 8'h01, rxd, tacn, tbcn, c1, d;
  logic [5:0] irq;
  logic txp, toutp, hoa, hob, busy, full, rxl, pok;
  logic [7:0] pgot;
  int pgot_n, bad_count = 0, comparisons = 0, n0, t, tog_n = 0;
  int irq_n [6] = '{0, 0, 0, 0, 0, 0};

  stp_unit i_stp_unit (.i_sys_clk(clk), .i_reset(rst), .i_serial_rx_pin(rxl),
    .i_timer_in_pin(tin), .i_hs_in_pin_a(hsa), .i_hs_in_pin_b(hsb), .o_serial_tx_pin(txp),
    .o_timer_out_pin(toutp), .o_hs_out_pin_a(hoa), .o_hs_out_pin_b(hob), .i_port_out(pout),
    .o_port_in(pin), .i_uart_en(uart), .i_parity_en(par), .i_tx_data(txd), .i_tx_load(txl),
    .o_tx_busy(busy), .o_rx_data(rxd), .o_rx_full(full), .i_rx_read(rxr), .i_hs0_en(h0e),
    .i_hs0_out(h0o), .i_hs1_en(h1e), .i_hs1_out(h1o), .i_hs2_en(h2e), .i_hs2_out(h2o),
    .i_dm_en(dme), .i_data_space_select_n(dsn), .i_tout_en(toe), .i_tout_sel(tsel),
    .i_ta_start(tas), .i_ta_stop(tap), .i_ta_resume(tar), .i_ta_cont(tac), .i_ta_init(tai),
    .i_ta_scale(tasc), .o_ta_count(tacn), .i_tb_start(tbs), .i_tb_stop(tbp),
    .i_tb_resume(tbr), .i_tb_cont(tbc), .i_tb_init(tbi), .i_tb_scale(tbsc),
    .o_tb_count(tbcn), .i_tb_ext_en(tbx), .i_tin_mode(tmode), .i_cascade(casc),
    .o_irq_zero(irq[0]), .o_irq_one(irq[1]), .o_irq_two(irq[2]), .o_irq_three(irq[3]),
    .o_irq_four(irq[4]), .o_irq_five(irq[5]));
  stp_peer #(.BIT(64)) i_stp_peer (.i_sys_clk(clk), .i_tx_line(txp), .o_rx_line(rxl),
    .o_got(pgot), .o_stop_ok(pok), .o_got_n(pgot_n));

  always #20 clk = ~clk;
  always @(posedge clk) for (int k = 0; k < 6; k++) if (irq[k] === 1'h1) irq_n[k]++;
  always @(toutp) tog_n++;

  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  function automatic int cnt(input int k);
    return (k == 6) ? pgot_n : irq_n[k];
  endfunction : cnt
  task automatic wait_cnt(input int k, input int base, input int lim, output int w);
    w = 0;
    while (cnt(k) == base && w < lim) begin
      @(posedge clk);
      #1;
      w++;
    end
    `CHK("event_seen", 1'h1, cnt(k) != base)
  endtask : wait_cnt
  // Tick phase is free running, so the first expiry gets a small window
  task automatic timer_run(input logic [7:0] n, input logic [5:0] s, input logic c);
    int tp;
    tp = ((n == 8'h00) ? 256 : n) * ((s == 6'h00) ? 64 : s) * 4;
    @(posedge clk);
    tbi <= n; tbsc <= s; tbc <= c; tbs <= 1'h1;
    @(posedge clk);
    tbs <= 1'h0;
    #1;
    n0 = irq_n[5];
    wait_cnt(5, n0, tp + 20, t);
    `CHK("tb_first", 1'h1, t >= tp - 4 && t <= tp + 8)
    if (c) begin
      wait_cnt(5, n0 + 1, tp + 20, t);
      `CHK("tb_period", tp, t)
    end else begin
      cyc(tp + 20);
      #1;
      `CHK("tb_single", n0 + 1, irq_n[5])
      `CHK("tb_reload", n, tbcn)
    end
    @(posedge clk);
    tbp <= 1'h1;
    @(posedge clk);
    tbp <= 1'h0;
  endtask : timer_run

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    void'($urandom(29290));
    cyc(12);
    rst <= 1'h0;
    cyc(2);
    #1;
    `CHK("tx_idle", 1'h1, txp)
    timer_run(8'h01, 6'h01, 1'h0);
    timer_run(8'h00, 6'h01, 1'h1);
    timer_run(8'h02, 6'h00, 1'h0);
    repeat (3) timer_run(8'($urandom_range(1, 20)), 6'($urandom_range(1, 8)), 1'($urandom));
    @(posedge clk);
    tbi <= 8'hc8; tbsc <= 6'h01; tbs <= 1'h1;
    @(posedge clk);
    tbs <= 1'h0;
    cyc(40);
    tbp <= 1'h1;
    @(posedge clk);
    tbp <= 1'h0;
    cyc(2);
    #1;
    c1 = tbcn;
    cyc(40);
    #1;
    `CHK("tb_hold", c1, tbcn)
    @(posedge clk);
    tbr <= 1'h1;
    @(posedge clk);
    tbr <= 1'h0;
    cyc(40);
    #1;
    `CHK("tb_resume", 1'h1, tbcn < c1 - 8'h07 && tbcn > c1 - 8'h0c)
    @(posedge clk);
    tbs <= 1'h1;
    @(posedge clk);
    tbs <= 1'h0;
    #1;
    `CHK("tb_restart", 1'h1, tbcn == 8'hc8 || tbcn == 8'hc7)
    // External clock: one decrement per rising edge at scale one
    @(posedge clk);
    tbx <= 1'h1; tmode <= 2'h0; tbi <= 8'h0a; tbs <= 1'h1;
    @(posedge clk);
    tbs <= 1'h0;
    repeat (3) begin
      cyc(8);
      tin <= 1'h1;
      cyc(8);
      tin <= 1'h0;
    end
    cyc(8);
    #1;
    `CHK("tb_ext", 8'h07, tbcn)
    @(posedge clk);
    tmode <= 2'h1; tbi <= 8'h40; tbs <= 1'h1;
    @(posedge clk);
    tbs <= 1'h0;
    cyc(20);
    #1;
    `CHK("tb_gate_low", 8'h40, tbcn)
    @(posedge clk);
    tin <= 1'h1;
    cyc(40);
    #1;
    `CHK("tb_gate_high", 1'h1, tbcn >= 8'h35 && tbcn <= 8'h38)
    @(posedge clk);
    tin <= 1'h0; tmode <= 2'h3; tbi <= 8'h20;
    cyc(8);
    tin <= 1'h1;
    cyc(4);
    #1;
    `CHK("tb_retrig", 1'h1, tbcn >= 8'h1f && tbcn <= 8'h20)
    @(posedge clk);
    tin <= 1'h0; tmode <= 2'h2;
    cyc(8);
    tin <= 1'h1;
    cyc(8);
    #1;
    `CHK("tb_no_retrig", 1'h1, tbcn <= 8'h1d)
    @(posedge clk);
    tbx <= 1'h0; tai <= 8'h01; tasc <= 6'h01; tac <= 1'h1; tas <= 1'h1; casc <= 1'h1;
    tbi <= 8'h64; tbc <= 1'h0; tbs <= 1'h1;
    @(posedge clk);
    tas <= 1'h0; tbs <= 1'h0;
    cyc(200);
    #1;
    `CHK("tb_cascade", 1'h1, tbcn >= 8'h30 && tbcn <= 8'h34)
    @(posedge clk);
    casc <= 1'h0; uart <= 1'h1; toe <= 1'h1; tsel <= 2'h0;
    // Load held a second cycle to show it is refused once busy
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      p = k[0];
      @(posedge clk);
      par <= p; txd <= d; txl <= 1'h1;
      @(posedge clk);
      txd <= ~d;
      #1;
      n0 = pgot_n;
      c1 = 8'(tog_n);
      @(posedge clk);
      txl <= 1'h0;
      #1;
      `CHK("tx_busy", 1'h1, busy)
      wait_cnt(6, n0, 900, t);
      `CHK("tx_byte", p ? {~^d[6:0], d[6:0]} : d, pgot)
      `CHK("tx_stops", 1'h1, pok)
      `CHK("tout_ta", 1'h1, 8'(tog_n - c1) > 8'h64)
      cyc(40);
      #1;
      `CHK("tx_done", 1'h0, busy)
    end
    @(posedge clk);
    tsel <= 2'h2;
    cyc(4);
    #1;
    c1 = 8'(tog_n);
    cyc(40);
    #1;
    `CHK("tout_clk", 8'h14, 8'(tog_n) - c1)
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      p = k[0];
      @(posedge clk);
      par <= p;
      #1;
      n0 = irq_n[3];
      if (k == 3) i_stp_peer.send(~d, 1);
      i_stp_peer.send(d, k + 1);
      wait_cnt(3, n0 + ((k == 3) ? 1 : 0), 200, t);
      `CHK("rx_byte", p ? {~^d, d[6:0]} : d, rxd)
      `CHK("rx_full", 1'h1, full)
      @(posedge clk);
      rxr <= 1'h1;
      @(posedge clk);
      rxr <= 1'h0;
      #1;
      `CHK("rx_clear", 1'h0, full)
    end
    @(posedge clk);
    uart <= 1'h0; toe <= 1'h0;
    repeat (8) begin
      @(posedge clk);
      {h0e, h0o, h1e, h1o, h2e, h2o, dme, dsn, pout} <= 12'($urandom);
      {hsa, hsb, tin} <= 3'($urandom);
      cyc(5);
      #1;
      `CHK("hs_a", h0e ? h0o : pout[1], hoa)
      `CHK("hs_b", dme ? dsn : (h1e ? h1o : pout[0]), hob)
      `CHK("tout", h2e ? h2o : pout[2], toutp)
      `CHK("tx_pin", pout[3], txp)
      `CHK("port_in", {hsb, hsa, tin, rxl}, pin)
    end
    // timer_a alone: read-back, stop, resume, single pass
    @(posedge clk);
    tai <= 8'h0a; tac <= 1'h0; tas <= 1'h1;
    @(posedge clk);
    tas <= 1'h0;
    cyc(20);
    #1;
    `CHK("ta_count", 8'h05, tacn)
    @(posedge clk);
    tap <= 1'h1;
    @(posedge clk);
    tap <= 1'h0;
    #1;
    c1 = tacn;
    cyc(12);
    #1;
    `CHK("ta_hold", c1, tacn)
    @(posedge clk);
    tar <= 1'h1;
    @(posedge clk);
    tar <= 1'h0;
    #1;
    n0 = irq_n[4];
    wait_cnt(4, n0, 40, t);
    cyc(40);
    #1;
    `CHK("ta_single", n0 + 1, irq_n[4])
    `CHK("ta_reload", 8'h0a, tacn)
    @(posedge clk);
    {hsa, hsb, tin} <= 3'h7;
    cyc(6);
    #1;
    n0 = irq_n[0] + irq_n[1] + irq_n[2];
    @(posedge clk);
    {hsa, hsb, tin} <= 3'h0;
    cyc(8);
    #1;
    `CHK("pin_irqs", n0 + 3, irq_n[0] + irq_n[1] + irq_n[2])
    summarize();
  end
endmodule : test_serial_timer_port_unit
`default_nettype wire
